// >>> hdl/pudc_pkg.sv
// Package: constants and carrier types for the up/down counter
package pudc_pkg;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_TOP = 4'hf;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic TC_IDLE = 1'b1;
    localparam logic CLK_RST = 1'b1;

    // Control pins sampled together each system clock
    typedef struct packed {
        logic clear;
        logic preset_n;
        logic up_clk;
        logic dn_clk;
    } pudc_ctrl_t;
endpackage : pudc_pkg

// >>> hdl/pudc_counter.sv
// Presettable 4-bit up/down counter with carry and borrow outputs
// How it works
// - Count changes only on a system clock rising edge
// - Up edge with down held high increments
// - Down edge with up held high decrements
// - Clear forces zero, beats everything else
// - Preset low loads data inputs, clocks ignored
// - At fifteen carry follows the up clock
// - At zero borrow follows the down clock
// - Low clock after clear/preset counts next rise
// - Counting wraps modulo sixteen
`timescale 1ns/1ps
`default_nettype none
module pudc_counter
    import pudc_pkg::*;
(
    input wire logic ref_clk_i,                    // 25 MHz system clock
    input wire logic srst_i,                       // Synchronous reset, active high
    input wire logic up_count_clock_i,             // Up count clock
    input wire logic down_count_clock_i,           // Down count clock
    input wire logic async_clear_i,                // Clear, active high
    input wire logic async_preset_n_i,             // Preset load, active low
    input wire logic [CNT_W-1:0] preset_in_i,      // Preset data, bit 0 first
    output logic [CNT_W-1:0] count_out_o,          // Count value
    output logic carry_out_n_o,                    // Carry, active low
    output logic borrow_out_n_o                    // Borrow, active low
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic at_value(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] t);
        at_value = (v == t);
    endfunction : at_value

    // ****************************************
    // Edge detection
    // ****************************************
    pudc_ctrl_t ctrl;
    logic up_prev_r;
    logic dn_prev_r;
    logic up_rise;
    logic dn_rise;
    logic overriding;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic carry_n_r;
    logic borrow_n_r;

    assign ctrl = '{clear: async_clear_i, preset_n: async_preset_n_i,
                    up_clk: up_count_clock_i, dn_clk: down_count_clock_i};

    // Previous levels track the pins even during clear or preset, so a clock
    // that stays low through an override still counts on its next rise.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            up_prev_r <= CLK_RST;
            dn_prev_r <= CLK_RST;
        end else begin
            up_prev_r <= ctrl.up_clk;
            dn_prev_r <= ctrl.dn_clk;
        end
    end

    assign overriding = ctrl.clear || !ctrl.preset_n;
    // The idle clock must have been high both now and before; a simultaneous
    // rise of both clocks is unpredictable and is dropped. Rises under an
    // override are swallowed, only the clock level is kept for later.
    assign up_rise = !overriding && ctrl.up_clk && !up_prev_r
                     && ctrl.dn_clk && dn_prev_r;
    assign dn_rise = !overriding && ctrl.dn_clk && !dn_prev_r
                     && ctrl.up_clk && up_prev_r;

    // ****************************************
    // Count
    // ****************************************
    always_comb begin
        if (ctrl.clear) begin
            count_nxt = CNT_ZERO;
        end else if (!ctrl.preset_n) begin
            count_nxt = preset_in_i;
        end else if (up_rise) begin
            count_nxt = CNT_W'(count_r + CNT_ONE);
        end else if (dn_rise) begin
            count_nxt = CNT_W'(count_r - CNT_ONE);
        end else begin
            count_nxt = count_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            count_r <= CNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ****************************************
    // Terminal count outputs
    // ****************************************
    // Built from the next count so they line up with count_out_o; this is
    // what lets a higher stage use them as its clocks.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            carry_n_r <= TC_IDLE;
            borrow_n_r <= TC_IDLE;
        end else begin
            carry_n_r <= !(at_value(count_nxt, CNT_TOP) && !ctrl.up_clk);
            borrow_n_r <= !(at_value(count_nxt, CNT_ZERO) && !ctrl.dn_clk);
        end
    end

    assign count_out_o = count_r;
    assign carry_out_n_o = carry_n_r;
    assign borrow_out_n_o = borrow_n_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_quiet;
        !async_clear_i && async_preset_n_i;
    endsequence

    sequence s_clear_low_up;
        async_clear_i && !up_count_clock_i
        ##1 (s_quiet and (!up_count_clock_i && down_count_clock_i));
    endsequence

    sequence s_up_edge;
        s_quiet and (up_count_clock_i && down_count_clock_i);
    endsequence

    // Clear with a clock held low, then released with that clock still low
    sequence s_clear_low_dn;
        async_clear_i && !down_count_clock_i
        ##1 (s_quiet and (!down_count_clock_i && up_count_clock_i));
    endsequence

    sequence s_dn_edge;
        s_quiet and (down_count_clock_i && up_count_clock_i);
    endsequence

    AST_CLEAR_ZERO: assert property (
        async_clear_i |=> count_out_o == CNT_ZERO)
        else $error("clear did not force zero");

    AST_PRESET_LOAD: assert property (
        !async_clear_i && !async_preset_n_i |=> count_out_o == $past(preset_in_i))
        else $error("preset did not load data");

    AST_COUNT_UP: assert property (
        s_quiet and up_rise |=> count_out_o == CNT_W'($past(count_out_o) + CNT_ONE))
        else $error("up edge did not increment");

    AST_COUNT_DOWN: assert property (
        s_quiet and dn_rise |=> count_out_o == CNT_W'($past(count_out_o) - CNT_ONE))
        else $error("down edge did not decrement");

    AST_HOLD: assert property (
        s_quiet and !up_rise and !dn_rise |=> $stable(count_out_o))
        else $error("count changed without an edge");

    AST_CARRY: assert property (
        ##1 carry_out_n_o == !(count_out_o == CNT_TOP && !$past(up_count_clock_i)))
        else $error("carry does not follow up clock at fifteen");

    AST_BORROW: assert property (
        ##1 borrow_out_n_o == !(count_out_o == CNT_ZERO && !$past(down_count_clock_i)))
        else $error("borrow does not follow down clock at zero");

    AST_IDLE_HIGH: assert property (
        count_out_o != CNT_TOP && count_out_o != CNT_ZERO |-> carry_out_n_o && borrow_out_n_o)
        else $error("terminal output low away from terminal count");

    AST_WRAP_UP: assert property (
        count_out_o == CNT_TOP and s_quiet and up_rise |=> count_out_o == CNT_ZERO)
        else $error("count did not wrap from fifteen to zero");

    AST_COUNT_AFTER_CLEAR: assert property (
        s_clear_low_up ##1 s_up_edge |=> count_out_o == CNT_ONE)
        else $error("rise after clear was not counted");

    AST_COUNT_DOWN_AFTER_CLEAR: assert property (
        s_clear_low_dn ##1 s_dn_edge |=> count_out_o == CNT_TOP)
        else $error("down rise after clear was not counted");

    AST_WRAP_DOWN: assert property (
        count_out_o == CNT_ZERO and s_quiet and dn_rise |=> count_out_o == CNT_TOP)
        else $error("count did not wrap from zero to fifteen");

    // Clear must also beat a load that is active in the same cycle
    AST_CLEAR_OVER_PRESET: assert property (
        async_clear_i && !async_preset_n_i |=> count_out_o == CNT_ZERO)
        else $error("preset won over clear");

    AST_CLEAR_BORROW: assert property (
        async_clear_i && !down_count_clock_i |=> !borrow_out_n_o)
        else $error("borrow not low during clear with down clock low");

    // A high count clock means no terminal pulse, whatever the count
    AST_CARRY_CLK_HIGH: assert property (
        up_count_clock_i |=> carry_out_n_o)
        else $error("carry low while up clock high");

    AST_BORROW_CLK_HIGH: assert property (
        down_count_clock_i |=> borrow_out_n_o)
        else $error("borrow low while down clock high");

    // A rise while the other clock is low is a driver fault and must not count
    AST_UP_LOCKED_OUT: assert property (
        s_quiet and (up_count_clock_i && !down_count_clock_i) |=> $stable(count_out_o))
        else $error("count moved while down clock low");

    AST_DN_LOCKED_OUT: assert property (
        s_quiet and (down_count_clock_i && !up_count_clock_i) |=> $stable(count_out_o))
        else $error("count moved while up clock low");

endmodule : pudc_counter
`default_nettype wire

// >>> tb/pudc_next_stage.sv
// Model of a cascaded higher-order stage clocked by carry and borrow
`timescale 1ns/1ps
`default_nettype none
module pudc_next_stage (
    input wire logic ref_clk_i, // System clock
    input wire logic srst_i,    // Synchronous reset
    input wire logic carry_n_i, // Up clock from lower stage
    input wire logic borrow_n_i, // Down clock from lower stage
    output logic [3:0] hi_o     // Higher-order count
);
    logic cy_r;
    logic bw_r;
    // Ripple stage: counts on the rise of the duplicated clocks
    always_ff @(posedge ref_clk_i) begin
        cy_r <= srst_i | carry_n_i;
        bw_r <= srst_i | borrow_n_i;
        if (srst_i) begin
            hi_o <= 4'h0;
        end else if (carry_n_i && !cy_r) begin
            hi_o <= hi_o + 4'h1;
        end else if (borrow_n_i && !bw_r) begin
            hi_o <= hi_o - 4'h1;
        end
    end
endmodule : pudc_next_stage
`default_nettype wire

// >>> tb/pudc_counter_bench.sv
// Self-checking bench for the up/down counter
`timescale 1ns/1ps
`default_nettype none
module pudc_counter_bench;
    import pudc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic up_i = CLK_RST;
    logic dn_i = CLK_RST;
    logic clr_i = 1'b0;
    logic pre_n_i = 1'b1;
    logic [CNT_W-1:0] din_i = CNT_ZERO;
    logic [CNT_W-1:0] cnt;
    logic [3:0] hi;
    logic cy_n;
    logic bw_n;
    logic [3:0] e;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    pudc_counter pudc_counter_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .up_count_clock_i(up_i), .down_count_clock_i(dn_i), .async_clear_i(clr_i),
        .async_preset_n_i(pre_n_i), .preset_in_i(din_i), .count_out_o(cnt),
        .carry_out_n_o(cy_n), .borrow_out_n_o(bw_n));
    pudc_next_stage pudc_next_stage_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .carry_n_i(cy_n), .borrow_n_i(bw_n), .hi_o(hi));
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    // Sized run is about 34 cycles, so 2000 only trips on a hang
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            error_cnt = error_cnt + 1;
            conclude();
        end
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic chk_tc(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk_tc
    // Pulse one count clock, the other held high
    task automatic step(input logic up, input logic [3:0] exp);
        logic tc_exp;
        tc_exp = ~(up ? (cnt === CNT_TOP) : (cnt === CNT_ZERO));
        if (up) up_i = 1'b0; else dn_i = 1'b0;
        @(negedge ref_clk_i);
        chk_tc(up ? cy_n : bw_n, tc_exp);
        up_i = 1'b1;
        dn_i = 1'b1;
        @(negedge ref_clk_i);
        chk(cnt, exp);
        chk_tc(cy_n, TC_IDLE);
        chk_tc(bw_n, TC_IDLE);
    endtask : step
    task automatic t_clear();
        clr_i = 1'b1;
        dn_i = 1'b0;
        pre_n_i = 1'b0;
        din_i = 4'h7;
        @(negedge ref_clk_i);
        chk(cnt, CNT_ZERO);
        chk_tc(bw_n, 1'b0);
        clr_i = 1'b0;
        pre_n_i = 1'b1;
        @(negedge ref_clk_i);
        dn_i = 1'b1;
        @(negedge ref_clk_i);
        chk(cnt, CNT_TOP);
        // The next stage sees the borrow rise one system clock later
        @(negedge ref_clk_i);
        chk(hi, 4'hf);
        $display("clear test done");
    endtask : t_clear
    task automatic t_load_count();
        pre_n_i = 1'b0;
        din_i = 4'hd;
        up_i = 1'b0;
        @(negedge ref_clk_i);
        up_i = 1'b1;
        @(negedge ref_clk_i);
        chk(cnt, 4'hd);
        pre_n_i = 1'b1;
        e = 4'hd;
        repeat (5) begin
            e = e + 4'h1;
            step(1'b1, e);
        end
        chk(hi, 4'h0);
        repeat (5) begin
            e = e - 4'h1;
            step(1'b0, e);
        end
        chk(hi, 4'hf);
        $display("load and count test done");
    endtask : t_load_count
    task automatic t_refused();
        dn_i = 1'b0;
        up_i = 1'b0;
        @(negedge ref_clk_i);
        up_i = 1'b1;
        @(negedge ref_clk_i);
        chk(cnt, 4'hd);
        dn_i = 1'b1;
        $display("refused edge test done");
    endtask : t_refused
    task automatic t_clear_up();
        clr_i = 1'b1;
        up_i = 1'b0;
        @(negedge ref_clk_i);
        chk(cnt, CNT_ZERO);
        chk_tc(bw_n, TC_IDLE);
        clr_i = 1'b0;
        @(negedge ref_clk_i);
        up_i = 1'b1;
        @(negedge ref_clk_i);
        chk(cnt, CNT_ONE);
        $display("clear with up low test done");
    endtask : t_clear_up
    initial begin
        repeat (3) @(negedge ref_clk_i);
        srst_i = 1'b0;
        chk(cnt, CNT_RST);
        t_clear();
        t_load_count();
        t_refused();
        t_clear_up();
        conclude();
    end
endmodule : pudc_counter_bench
`default_nettype wire
